// >>> ext_irq_unit.sv
// external pin and key input interrupt unit with priority resolution, APB registers.
// assumes pins are asynchronous; the CPU acknowledges the presented request with IRQ_ACK.
//
// Notes on behaviour
// - of requests pending together, only the highest priority one is acknowledged.
// - equal programmed levels are resolved by fixed source order, lowest number first.
// - special non-maskable sources have fixed hardware priority above all maskable ones.
// - software interrupt entry ignores arbitration, masking and levels entirely.
// - one selection circuit presents only the single best request to the CPU.
// - each external input raises requests only while its enable bit is 1.
// - pin route bit picks primary pin at 0, alternate pin at 1.
// - enable registers hold enables in even bits, edge modes in odd bits.
// - rewriting enable registers may set request flags spuriously; this is allowed.
// - two-bit filter field: none, f1, f8 or f32 sampling.
// - filtered level accepted only after three matching samples on sampling clock.
// - external input zero also drives a timer trigger and pulse cutoff input.
// - a selected key edge with no other enabled key held active raises one shared key request, which also wakes.
// - each key input has its own enable bit and polarity bit.
// - an enabled key held active masks edges of the other keys.
// - maskable request needs global enable, request flag, and level above processor level.
// - level field zero disables a source; one to seven rise in priority.
// - key polarity bit zero selects falling edge, one selects rising edge.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module ext_irq_unit
  import ext_irq_pkg::*;
(
  // clock and reset
  input  logic                   CLOCK,
  input  logic                   RESET,
  // apb slave
  input  logic                   PSEL,
  input  logic                   PENABLE,
  input  logic                   PWRITE,
  input  logic [APB_ADDR_W-1:0]  PADDR,
  input  logic [31:0]            PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // pins
  input  logic [NUM_EXT-1:0]     EXT_PIN_PRIMARY,
  input  logic [NUM_EXT-1:0]     EXT_PIN_ALTERNATE,
  input  logic [NUM_KEY-1:0]     KEY_PIN,
  // cpu side
  input  logic                   GLOBAL_ENABLE,
  input  logic [2:0]             PROCESSOR_LEVEL,
  input  logic [NUM_SPECIAL-1:0] SPECIAL_REQ,
  input  logic                   SW_INT,
  input  logic                   IRQ_ACK,
  output logic                   IRQ_REQ,
  output logic [3:0]             IRQ_SOURCE,
  output logic [2:0]             IRQ_LEVEL,
  output logic                   SW_ENTER,
  output logic                   KEY_WAKE,
  // timer hookups of external input zero
  output logic                   TIMER_TRIGGER,
  output logic                   PULSE_CUTOFF
);

  localparam int SYNC_W = 2 * NUM_EXT + NUM_KEY;

  // register file
  logic [7:0]         ext_irq_pin_route;
  logic [7:0]         ext_irq_enable_lo;
  logic [7:0]         ext_irq_enable_hi;
  logic [7:0]         ext_irq_filter_lo;
  logic [7:0]         ext_irq_filter_hi;
  logic [7:0]         key_enable_lo;
  logic [7:0]         key_enable_hi;
  logic [2:0]         priority_level_field [NUM_SRC];
  logic [NUM_SRC-1:0] request_flag;
  logic [NUM_EXT-1:0] edge_direction_bit;

  // pin path
  logic [SYNC_W-1:0]     sync_stage1;
  logic [SYNC_W-1:0]     sync_stage2;
  logic [NUM_EXT-1:0]    ext_irq_input;
  logic [NUM_EXT-1:0]    filtered_level;
  logic [NUM_EXT-1:0]    gated_level;
  logic [NUM_EXT-1:0]    gated_prev;
  logic [NUM_KEY-1:0]    key_input;
  logic                  key_combined;
  logic                  key_prev;
  logic [NUM_SRC-1:0]    source_event;
  logic [PRESCALE_W-1:0] prescale;
  logic                  strobe_f8;
  logic                  strobe_f32;

  // bus decode
  logic             bus_setup;
  logic             bus_write;
  logic [IDX_W-1:0] bus_index;

  // arbitration
  logic               next_req;
  logic [3:0]         next_source;
  logic [2:0]         next_level;
  logic               ack_maskable;

  logic [15:0] enable_field;
  logic [15:0] filter_field;
  logic [15:0] key_field;

  assign enable_field = {ext_irq_enable_hi, ext_irq_enable_lo};
  assign filter_field = {ext_irq_filter_hi, ext_irq_filter_lo};
  assign key_field    = {key_enable_hi, key_enable_lo};

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = (idx == IDX_PIN_ROUTE) || (idx >= IDX_ENABLE_LO && idx <= IDX_KEY_EN_HI) ||
                (idx >= IDX_CTRL_BASE && idx <= IDX_KEY_CTRL);
  endfunction

  function automatic logic strobe_for(input filter_mode_t mode, input logic s8, input logic s32);
    unique case (mode)
      FILT_NONE: strobe_for = 1'b0;
      FILT_F1:   strobe_for = 1'b1;
      FILT_F8:   strobe_for = s8;
      FILT_F32:  strobe_for = s32;
    endcase
  endfunction

  assign bus_index = PADDR[APB_ADDR_W-1:2];
  assign bus_setup = PSEL & ~PENABLE;
  assign bus_write = PSEL & PENABLE & PWRITE;

  // zero wait states: every access completes in its first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~is_mapped(bus_index);

  // configuration registers
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ext_irq_pin_route <= REG8_RESET;
      ext_irq_enable_lo <= REG8_RESET;
      ext_irq_enable_hi <= REG8_RESET;
      ext_irq_filter_lo <= REG8_RESET;
      ext_irq_filter_hi <= REG8_RESET;
      key_enable_lo     <= REG8_RESET;
      key_enable_hi     <= REG8_RESET;
    end else if (bus_write) begin
      unique case (bus_index)
        IDX_PIN_ROUTE: ext_irq_pin_route <= PWDATA[7:0];
        IDX_ENABLE_LO: ext_irq_enable_lo <= PWDATA[7:0];
        IDX_ENABLE_HI: ext_irq_enable_hi <= PWDATA[7:0];
        IDX_FILTER_LO: ext_irq_filter_lo <= PWDATA[7:0];
        IDX_FILTER_HI: ext_irq_filter_hi <= PWDATA[7:0];
        IDX_KEY_EN_LO: key_enable_lo     <= PWDATA[7:0];
        IDX_KEY_EN_HI: key_enable_hi     <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // read data registered in the setup cycle, valid throughout the access cycle
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0;
    end else if (bus_setup) begin
      PRDATA <= 32'h0;
      if (bus_index >= IDX_CTRL_BASE && bus_index <= IDX_KEY_CTRL) begin
        PRDATA[CTRL_LEVEL_MSB:CTRL_LEVEL_LSB] <= priority_level_field[4'(bus_index - IDX_CTRL_BASE)];
        PRDATA[CTRL_REQ_BIT] <= request_flag[4'(bus_index - IDX_CTRL_BASE)];
        if (bus_index != IDX_KEY_CTRL) begin
          PRDATA[CTRL_DIR_BIT] <= edge_direction_bit[3'(bus_index - IDX_CTRL_BASE)];
        end
      end else begin
        unique case (bus_index)
          IDX_PIN_ROUTE: PRDATA[7:0] <= ext_irq_pin_route;
          IDX_ENABLE_LO: PRDATA[7:0] <= ext_irq_enable_lo;
          IDX_ENABLE_HI: PRDATA[7:0] <= ext_irq_enable_hi;
          IDX_FILTER_LO: PRDATA[7:0] <= ext_irq_filter_lo;
          IDX_FILTER_HI: PRDATA[7:0] <= ext_irq_filter_hi;
          IDX_KEY_EN_LO: PRDATA[7:0] <= key_enable_lo;
          IDX_KEY_EN_HI: PRDATA[7:0] <= key_enable_hi;
          default:       PRDATA[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // two-flop synchronisers for all pins
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      sync_stage1 <= {SYNC_W{PIN_IDLE}};
      sync_stage2 <= {SYNC_W{PIN_IDLE}};
    end else begin
      sync_stage1 <= {KEY_PIN, EXT_PIN_ALTERNATE, EXT_PIN_PRIMARY};
      sync_stage2 <= sync_stage1;
    end
  end

  // sampling clock prescaler for f8 and f32
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + PRESCALE_STEP;
    end
  end

  assign strobe_f8  = (prescale[2:0] == F8_MATCH);
  assign strobe_f32 = (prescale == F32_MATCH);

  // external inputs: route, filter, gate, edge detect
  for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
    filter_mode_t mode;
    logic         rise;
    logic         fall;

    assign mode = filter_mode_t'(filter_field[2*i+1 -: 2]);
    assign ext_irq_input[i] = ext_irq_pin_route[i] ? sync_stage2[NUM_EXT+i] : sync_stage2[i];

    input_sample_filter u_filter (
      .clock         (CLOCK),
      .reset         (RESET),
      .pin_level     (ext_irq_input[i]),
      .sample_strobe (strobe_for(mode, strobe_f8, strobe_f32)),
      .filter_on     (mode != FILT_NONE),
      .level         (filtered_level[i])
    );

    // disabled input rests at idle, so enabling on an active pin can raise a flag
    assign gated_level[i] = enable_field[2*i] ? filtered_level[i] : PIN_IDLE;
    assign rise = ~gated_prev[i] & gated_level[i];
    assign fall = gated_prev[i] & ~gated_level[i];
    assign source_event[i] = enable_field[2*i] &
                             (enable_field[2*i+1] ? (rise | fall) :
                              (edge_direction_bit[i] ? rise : fall));
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      gated_prev <= {NUM_EXT{PIN_IDLE}};
    end else begin
      gated_prev <= gated_level;
    end
  end

  // key inputs: one combined active signal, edge on it
  for (genvar k = 0; k < NUM_KEY; k++) begin : g_key
    assign key_input[k] = key_field[2*k] & (key_field[2*k+1] ? sync_stage2[2*NUM_EXT+k]
                                                              : ~sync_stage2[2*NUM_EXT+k]);
  end

  // a key held active keeps the combined signal high and hides other keys
  assign key_combined = |key_input;
  assign source_event[NUM_EXT] = key_combined & ~key_prev;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      key_prev <= 1'b0;
    end else begin
      key_prev <= key_combined;
    end
  end

  assign ack_maskable = IRQ_ACK & IRQ_REQ & ~SW_INT & (IRQ_SOURCE < SRC_SPECIAL_BASE);

  // per-source control registers; a hardware set beats software or ack clear
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_ctrl
    logic hit;
    assign hit = bus_write && (bus_index == IDX_CTRL_BASE + IDX_W'(s));

    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        priority_level_field[s] <= LEVEL_RESET;
      end else if (hit) begin
        priority_level_field[s] <= PWDATA[CTRL_LEVEL_MSB:CTRL_LEVEL_LSB];
      end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        request_flag[s] <= 1'b0;
      end else if (source_event[s]) begin
        request_flag[s] <= 1'b1;
      end else if (hit && !PWDATA[CTRL_REQ_BIT]) begin
        request_flag[s] <= 1'b0;
      end else if (ack_maskable && IRQ_SOURCE == 4'(s)) begin
        request_flag[s] <= 1'b0;
      end
    end

    if (s < NUM_EXT) begin : g_dir
      always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
          edge_direction_bit[s] <= 1'b0;
        end else if (hit) begin
          edge_direction_bit[s] <= PWDATA[CTRL_DIR_BIT];
        end
      end
    end
  end

  // level selection circuit: special first, then best maskable level
  always_comb begin
    logic [2:0] best_level;
    logic [3:0] best_source;
    logic       found;
    best_level  = LEVEL_NONE;
    best_source = 4'h0;
    found       = 1'b0;
    for (int s = 0; s < NUM_SRC; s++) begin
      // strict compare keeps the lowest source number on a tie
      if (GLOBAL_ENABLE && request_flag[s] && priority_level_field[s] > PROCESSOR_LEVEL &&
          priority_level_field[s] > best_level) begin
        best_level  = priority_level_field[s];
        best_source = 4'(s);
        found       = 1'b1;
      end
    end
    for (int p = NUM_SPECIAL - 1; p >= 0; p--) begin
      if (SPECIAL_REQ[p]) begin
        best_level  = LEVEL_TOP;
        best_source = SRC_SPECIAL_BASE + 4'(p);
        found       = 1'b1;
      end
    end
    next_req    = found;
    next_source = best_source;
    next_level  = best_level;
  end

  // only the single winner is presented to the cpu
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      IRQ_REQ    <= 1'b0;
      IRQ_SOURCE <= 4'h0;
      IRQ_LEVEL  <= LEVEL_NONE;
    end else begin
      IRQ_REQ    <= next_req;
      IRQ_SOURCE <= next_source;
      IRQ_LEVEL  <= next_level;
    end
  end

  // software interrupt entry never waits for or touches arbitration
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      SW_ENTER <= 1'b0;
    end else begin
      SW_ENTER <= SW_INT;
    end
  end

  // wake-up is independent of global enable and processor level
  assign KEY_WAKE = request_flag[NUM_EXT];

  // timer hookups follow the accepted level of input zero, whatever its enable
  assign TIMER_TRIGGER = filtered_level[0];
  assign PULSE_CUTOFF  = filtered_level[0];

endmodule // ext_irq_unit

// >>> ext_irq_pkg.sv
// constants for the external pin interrupt unit: register indices, field positions,
// reset values, sampling dividers and source numbering.
// assumes a 32-bit APB slave where byte address = 4 * register index.
package ext_irq_pkg;

  // counts of sources
  localparam int NUM_EXT     = 8;
  localparam int NUM_KEY     = 8;
  localparam int NUM_SPECIAL = 3;
  localparam int NUM_SRC     = NUM_EXT + 1;

  // bus geometry
  localparam int APB_ADDR_W = 12;
  localparam int IDX_W      = 10;

  // register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_PIN_ROUTE   = 10'h18E;
  localparam logic [IDX_W-1:0] IDX_ENABLE_LO   = 10'h1FA;
  localparam logic [IDX_W-1:0] IDX_ENABLE_HI   = 10'h1FB;
  localparam logic [IDX_W-1:0] IDX_FILTER_LO   = 10'h1FC;
  localparam logic [IDX_W-1:0] IDX_FILTER_HI   = 10'h1FD;
  localparam logic [IDX_W-1:0] IDX_KEY_EN_LO   = 10'h1FE;
  localparam logic [IDX_W-1:0] IDX_KEY_EN_HI   = 10'h1FF;
  localparam logic [IDX_W-1:0] IDX_CTRL_BASE   = 10'h048;
  localparam logic [IDX_W-1:0] IDX_KEY_CTRL    = 10'h050;

  // per_source_control_reg fields
  localparam int CTRL_LEVEL_LSB = 0;
  localparam int CTRL_LEVEL_MSB = 2;
  localparam int CTRL_REQ_BIT   = 3;
  localparam int CTRL_DIR_BIT   = 4;

  // reset values
  localparam logic [7:0]  REG8_RESET   = 8'h00;
  localparam logic [2:0]  LEVEL_RESET  = 3'h0;
  localparam logic        PIN_IDLE     = 1'b1;

  // priority levels
  localparam logic [2:0] LEVEL_TOP     = 3'h7;
  localparam logic [2:0] LEVEL_NONE    = 3'h0;

  // sampling clock dividers
  localparam int           PRESCALE_W  = 5;
  localparam logic [2:0]   F8_MATCH    = 3'h7;
  localparam logic [4:0]   F32_MATCH   = 5'h1F;
  localparam logic [4:0]   PRESCALE_STEP = 5'h01;

  // source numbering seen by the CPU
  localparam logic [3:0] SRC_KEY          = 4'h8;
  localparam logic [3:0] SRC_SPECIAL_BASE = 4'h9;

  typedef enum logic [1:0] {
    FILT_NONE = 2'h0,
    FILT_F1   = 2'h1,
    FILT_F8   = 2'h2,
    FILT_F32  = 2'h3
  } filter_mode_t;

endpackage

// >>> input_sample_filter.sv
// three-sample digital filter for one synchronised interrupt input.
// assumes pin_level already passed a two-flop synchroniser on clock.
`timescale 1ns/1ns
module input_sample_filter
  import ext_irq_pkg::*;
(
  // clock and reset
  input  logic clock,
  input  logic reset,
  // input and sampling control
  input  logic pin_level,
  input  logic sample_strobe,
  input  logic filter_on,
  // accepted level
  output logic level
);

  logic [1:0] history;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      history <= {2{PIN_IDLE}};
      level   <= PIN_IDLE;
    end else if (!filter_on) begin
      // no filter: follow the synchronised pin directly
      history <= {2{pin_level}};
      level   <= pin_level;
    end else if (sample_strobe) begin
      history <= {history[0], pin_level};
      if (history[1] == pin_level && history[0] == pin_level) begin
        level <= pin_level;
      end
    end
  end

endmodule // input_sample_filter

// >>> ext_irq_sva.sv
// checker for ext_irq_unit: cpu request, software entry, key flag and timer hookups.
// assumes one clock domain; bound to every instance of the unit.
`timescale 1ns/1ns
module ext_irq_sva
  import ext_irq_pkg::*;
(
  // clock and reset
  input logic                   CLOCK,
  input logic                   RESET,
  // apb
  input logic                   PSEL,
  input logic                   PENABLE,
  input logic                   PWRITE,
  // cpu side
  input logic                   GLOBAL_ENABLE,
  input logic [2:0]             PROCESSOR_LEVEL,
  input logic [NUM_SPECIAL-1:0] SPECIAL_REQ,
  input logic                   SW_INT,
  input logic                   IRQ_ACK,
  input logic                   IRQ_REQ,
  input logic [3:0]             IRQ_SOURCE,
  input logic [2:0]             IRQ_LEVEL,
  input logic                   SW_ENTER,
  input logic                   KEY_WAKE,
  input logic                   TIMER_TRIGGER,
  input logic                   PULSE_CUTOFF
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_special_first: assert property (
    SPECIAL_REQ[0] |=> IRQ_REQ && IRQ_SOURCE == SRC_SPECIAL_BASE && IRQ_LEVEL == LEVEL_TOP)
    else $error("special source 0 not presented");
  a_special_order: assert property (
    SPECIAL_REQ == 3'h6 |=> IRQ_SOURCE == 4'hA) else $error("special order wrong");
  a_level_above: assert property (
    IRQ_REQ && IRQ_SOURCE < SRC_SPECIAL_BASE |-> $past(GLOBAL_ENABLE) && IRQ_LEVEL > $past(PROCESSOR_LEVEL))
    else $error("maskable request not above processor level");
  a_masked_quiet: assert property (
    !GLOBAL_ENABLE && SPECIAL_REQ == 3'h0 |=> !IRQ_REQ) else $error("request while masked");
  a_sw_bypass: assert property (SW_INT |=> SW_ENTER) else $error("software entry missed");
  a_level_nonzero: assert property (IRQ_REQ |-> IRQ_LEVEL != LEVEL_NONE) else $error("level zero presented");
  a_one_source: assert property (IRQ_REQ |-> IRQ_SOURCE <= 4'hB) else $error("bad source number");
  a_timer_pair: assert property (TIMER_TRIGGER == PULSE_CUTOFF) else $error("timer hookups differ");
  a_key_hold: assert property (
    KEY_WAKE && !IRQ_ACK && !(PSEL && PENABLE && PWRITE) |=> KEY_WAKE) else $error("key flag lost");

  c_key_req: cover property (IRQ_REQ && IRQ_SOURCE == SRC_KEY);
  c_sw: cover property (SW_ENTER);
  c_ack: cover property (IRQ_ACK && IRQ_REQ);
endmodule // ext_irq_sva

bind ext_irq_unit ext_irq_sva chk (
  .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .GLOBAL_ENABLE(GLOBAL_ENABLE), .PROCESSOR_LEVEL(PROCESSOR_LEVEL), .SPECIAL_REQ(SPECIAL_REQ),
  .SW_INT(SW_INT), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_SOURCE(IRQ_SOURCE),
  .IRQ_LEVEL(IRQ_LEVEL), .SW_ENTER(SW_ENTER), .KEY_WAKE(KEY_WAKE),
  .TIMER_TRIGGER(TIMER_TRIGGER), .PULSE_CUTOFF(PULSE_CUTOFF));

// >>> pin_model.sv
// far side model: external interrupt pins and key switches.
// assumes wanted levels change just after a rising edge; pins rest high.
`timescale 1ns/1ns
module pin_model
  import ext_irq_pkg::*;
(
  // clock
  input  logic               clock,
  // wanted levels
  input  logic [NUM_EXT-1:0] want_primary,
  input  logic [NUM_EXT-1:0] want_alternate,
  input  logic [NUM_KEY-1:0] want_key,
  // pins
  output logic [NUM_EXT-1:0] primary,
  output logic [NUM_EXT-1:0] alternate,
  output logic [NUM_KEY-1:0] key
);
  // pins move only on edges, so every change is asynchronous to nothing but the bench
  always_ff @(posedge clock) begin
    primary   <= want_primary;
    alternate <= want_alternate;
    key       <= want_key;
  end
endmodule // pin_model

// >>> tb.sv
// bench for ext_irq_unit: apb registers, pin edges, priority, filter and keys.
// assumes a zero-wait apb slave; pins come from pin_model and rest high.
`timescale 1ns/1ns
module tb;
  import ext_irq_pkg::*;
  logic                   clock = 1'h0, reset = 1'h1;
  logic                   psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [APB_ADDR_W-1:0]  paddr = '0;
  logic [31:0]            pwdata = '0, prdata;
  logic                   pready, pslverr;
  logic [NUM_EXT-1:0]     want_p = '1, want_a = '1, pin_p, pin_a;
  logic [NUM_KEY-1:0]     want_k = '1, pin_k;
  logic                   gen = 1'h0, sw_int = 1'h0, ack = 1'h0;
  logic [2:0]             plevel = 3'h0, irq_lvl;
  logic [NUM_SPECIAL-1:0] special = '0;
  logic [3:0]             irq_src;
  logic                   irq_req, sw_enter, key_wake, trig, cutoff;
  int                     mismatches = 0, n_compared = 0, cycles = 0;

  ext_irq_unit dut (
    .CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_PIN_PRIMARY(pin_p),
    .EXT_PIN_ALTERNATE(pin_a), .KEY_PIN(pin_k), .GLOBAL_ENABLE(gen), .PROCESSOR_LEVEL(plevel),
    .SPECIAL_REQ(special), .SW_INT(sw_int), .IRQ_ACK(ack), .IRQ_REQ(irq_req), .IRQ_SOURCE(irq_src),
    .IRQ_LEVEL(irq_lvl), .SW_ENTER(sw_enter), .KEY_WAKE(key_wake), .TIMER_TRIGGER(trig),
    .PULSE_CUTOFF(cutoff));
  pin_model pins (
    .clock(clock), .want_primary(want_p), .want_alternate(want_a), .want_key(want_k),
    .primary(pin_p), .alternate(pin_a), .key(pin_k));

  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, idx, {24'h0, d}, r, e);
  endtask
  task automatic rchk(input string name, input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'h0, idx, 32'h0, r, e);
    check(name, r[7:0], exp);
  endtask
  task automatic chk_irq(input string name, input logic [3:0] src, input logic [2:0] lvl);
    check(name, {irq_req, irq_src, irq_lvl}, {1'h1, src, lvl});
  endtask
  task automatic ack_pulse();
    ack <= 1'h1;
    step(1);
    ack <= 1'h0;
    step(3);
  endtask

  task automatic t_regs();
    logic [IDX_W-1:0] idx[7] = '{IDX_PIN_ROUTE, IDX_ENABLE_LO, IDX_ENABLE_HI, IDX_FILTER_LO,
                                 IDX_FILTER_HI, IDX_KEY_EN_LO, IDX_KEY_EN_HI};
    logic [31:0]      r;
    logic             e;
    foreach (idx[k]) rchk("reset value", idx[k], 8'h00);
    foreach (idx[k]) begin
      wr(idx[k], 8'hA5);
      rchk("readback", idx[k], 8'hA5);
      wr(idx[k], 8'h00);
    end
    apb(1'h0, 10'h000, 32'h0, r, e);
    check("unmapped error", 8'(e), 8'h01);
    check("unmapped data", 8'(|r), 8'h00);
  endtask

  task automatic t_ext();
    wr(IDX_ENABLE_LO, 8'h01);
    wr(IDX_CTRL_BASE, 8'h03);  // also drops a flag the enable write may have set
    wr(IDX_CTRL_BASE + 10'h1, 8'h00);
    want_p[1:0] <= 2'h0;
    step(8);
    chk_irq("ext0 request", 4'h0, 3'h3);
    rchk("ext0 flag", IDX_CTRL_BASE, 8'h0B);
    rchk("disabled input", IDX_CTRL_BASE + 10'h1, 8'h00);
    check("timer hookups", 8'({trig, cutoff}), 8'h00);
    gen <= 1'h0;
    step(3);
    check("masked", 8'(irq_req), 8'h00);
    sw_int <= 1'h1;
    step(1);
    sw_int <= 1'h0;
    step(1);
    check("software entry", 8'(sw_enter), 8'h01);
    gen <= 1'h1;
    step(3);
    ack_pulse();
    rchk("ack clears", IDX_CTRL_BASE, 8'h03);
    want_p[1:0] <= 2'h3;
    step(8);
    rchk("rising ignored", IDX_CTRL_BASE, 8'h03);
    check("timer released", 8'({trig, cutoff}), 8'h03);
    wr(IDX_CTRL_BASE, 8'h13);
    want_p[0] <= 1'h0;
    step(8);
    rchk("falling ignored", IDX_CTRL_BASE, 8'h13);
    want_p[0] <= 1'h1;
    step(8);
    rchk("rising taken", IDX_CTRL_BASE, 8'h1B);
    wr(IDX_ENABLE_LO, 8'h00);
    wr(IDX_CTRL_BASE, 8'h00);
  endtask

  task automatic t_prio();
    logic [2:0] lv[8] = '{3'h0, 3'h0, 3'h4, 3'h4, 3'h0, 3'h6, 3'h0, 3'h0};
    logic [2:0] sp[3] = '{3'h7, 3'h6, 3'h4};
    wr(IDX_ENABLE_LO, 8'h55);
    wr(IDX_ENABLE_HI, 8'h55);
    for (int i = 0; i < NUM_EXT; i++) wr(IDX_CTRL_BASE + 10'(i), {5'h00, lv[i]});
    want_p <= 8'hD2;
    step(8);
    chk_irq("highest level", 4'h5, 3'h6);
    ack_pulse();
    chk_irq("tie lowest number", 4'h2, 3'h4);
    plevel <= 3'h4;
    step(3);
    check("level not above", 8'(irq_req), 8'h00);
    plevel <= 3'h3;
    step(3);
    chk_irq("level above", 4'h2, 3'h4);
    foreach (sp[k]) begin
      special <= sp[k];
      step(3);
      chk_irq("special", SRC_SPECIAL_BASE + 4'(k), LEVEL_TOP);
    end
    special <= '0;
    step(3);
    rchk("level zero held", IDX_CTRL_BASE, 8'h08);
    ack_pulse();
    chk_irq("tie second", 4'h3, 3'h4);
    ack_pulse();
    check("all served", 8'(irq_req), 8'h00);
    want_p <= '1;
    plevel <= 3'h0;
    for (int i = 0; i < NUM_EXT; i++) wr(IDX_CTRL_BASE + 10'(i), 8'h00);
    wr(IDX_ENABLE_LO, 8'h00);
    wr(IDX_ENABLE_HI, 8'h00);
  endtask

  task automatic t_route();
    wr(IDX_PIN_ROUTE, 8'h08);  // routing goes first
    wr(IDX_ENABLE_LO, 8'h40);
    wr(IDX_CTRL_BASE + 10'h3, 8'h02);
    want_p[3] <= 1'h0;
    step(8);
    rchk("primary ignored", IDX_CTRL_BASE + 10'h3, 8'h02);
    want_a[3] <= 1'h0;
    step(8);
    rchk("alternate taken", IDX_CTRL_BASE + 10'h3, 8'h0A);
    want_p[3] <= 1'h1;
    want_a[3] <= 1'h1;
    wr(IDX_ENABLE_LO, 8'h00);
    wr(IDX_CTRL_BASE + 10'h3, 8'h00);
    wr(IDX_PIN_ROUTE, 8'h00);
  endtask

  task automatic t_both();
    wr(IDX_CTRL_BASE + 10'h4, 8'h01);  // falling direction before both edges
    wr(IDX_ENABLE_HI, 8'h03);
    wr(IDX_CTRL_BASE + 10'h4, 8'h01);
    want_p[4] <= 1'h0;
    step(8);
    rchk("falling edge", IDX_CTRL_BASE + 10'h4, 8'h09);
    wr(IDX_CTRL_BASE + 10'h4, 8'h01);
    want_p[4] <= 1'h1;
    step(8);
    rchk("rising edge", IDX_CTRL_BASE + 10'h4, 8'h09);
    wr(IDX_ENABLE_HI, 8'h00);
    wr(IDX_CTRL_BASE + 10'h4, 8'h00);
  endtask

  task automatic t_filter();
    int glen[4] = '{0, 2, 10, 60};
    wr(IDX_ENABLE_HI, 8'h10);
    for (int m = 1; m < 4; m++) begin
      wr(IDX_FILTER_HI, 8'(m << 4));
      wr(IDX_CTRL_BASE + 10'h6, 8'h01);
      want_p[6] <= 1'h0;
      step(glen[m]);
      want_p[6] <= 1'h1;
      step(100);
      rchk("short pulse", IDX_CTRL_BASE + 10'h6, 8'h01);
      want_p[6] <= 1'h0;
      step(200);
      rchk("long pulse", IDX_CTRL_BASE + 10'h6, 8'h09);
      want_p[6] <= 1'h1;
      step(200);
    end
    wr(IDX_FILTER_HI, 8'h00);
    wr(IDX_ENABLE_HI, 8'h00);
    wr(IDX_CTRL_BASE + 10'h6, 8'h00);
  endtask

  task automatic t_key();
    wr(IDX_KEY_EN_LO, 8'h05);
    wr(IDX_KEY_CTRL, 8'h02);
    want_k[0] <= 1'h0;
    step(8);
    check("key wake", 8'(key_wake), 8'h01);
    chk_irq("key source", SRC_KEY, 3'h2);
    wr(IDX_KEY_CTRL, 8'h02);
    want_k[1] <= 1'h0;
    step(8);
    check("held key masks", 8'(key_wake), 8'h00);
    want_k <= 8'hFB;
    step(8);
    check("disabled key", 8'(key_wake), 8'h00);
    wr(IDX_KEY_EN_LO, 8'h30);
    wr(IDX_KEY_CTRL, 8'h02);
    want_k[2] <= 1'h1;
    step(8);
    check("rising key", 8'(key_wake), 8'h01);
    wr(IDX_KEY_EN_LO, 8'h00);
    wr(IDX_KEY_CTRL, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'h0;
    step(2);
    t_regs();
    gen <= 1'h1;
    t_ext();
    t_prio();
    t_route();
    t_both();
    t_filter();
    t_key();
    finish_test();
  end
endmodule // tb
